// ---- rtl/lpt_panel_timing.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpt_panel_timing #(
  parameter int LSYNC_PIX = 8
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [lpt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic                            line_sync_o,
  output logic                            frame_sync_o,
  output logic                            panel_data_enable_o,
  output logic                            irq_o
);

  lpt_pkg::lpt_cfg_t      cfg;
  lpt_pkg::lpt_sync_t     sync;
  lpt_pkg::lpt_evt_t      evt;
  lpt_pkg::lpt_apb_state_t state;
  lpt_pkg::lpt_apb_state_t next_state;
  logic [lpt_pkg::IRQ_W-1:0] irq_status;
  logic [lpt_pkg::IRQ_W-1:0] irq_enable;
  logic [lpt_pkg::IRQ_W-1:0] next_status;
  logic [31:0]             next_rdata;
  logic                    next_err;

  // Decode
  wire [7:0] idx      = 8'(paddr_i >> lpt_pkg::IDX_LSB);
  wire       aligned  = (paddr_i[lpt_pkg::IDX_LSB-1:0] == '0);
  // Upper bits must be zero, else high addresses would alias registers
  wire       in_range = (paddr_i[lpt_pkg::ADDR_W-1:lpt_pkg::IDX_LSB+8] == '0);
  wire       setup    = psel_i && !penable_i;
  wire       commit   = psel_i && penable_i && pready_o;
  wire       wr       = commit && pwrite_i && !pslverr_o;
  wire [7:0] wd       = pwdata_i[7:0];
  wire       hit_mode = (idx == lpt_pkg::IDX_PANEL_MODE);
  wire       hit_pwr  = (idx == lpt_pkg::IDX_POWER_MODE);
  wire       hit_hs   = (idx == lpt_pkg::IDX_HSIZE);
  wire       hit_vlo  = (idx == lpt_pkg::IDX_VSIZE_LO);
  wire       hit_vhi  = (idx == lpt_pkg::IDX_VSIZE_HI);
  wire       hit_ls   = (idx == lpt_pkg::IDX_LSYNC_POS);
  wire       hit_hb   = (idx == lpt_pkg::IDX_HBLANK);
  wire       hit_fs   = (idx == lpt_pkg::IDX_FSYNC_POS);
  wire       hit_vb   = (idx == lpt_pkg::IDX_VBLANK);
  wire       hit_ist  = (idx == lpt_pkg::IDX_IRQ_STATUS);
  wire       hit_icl  = (idx == lpt_pkg::IDX_IRQ_CLEAR);
  wire       hit_ien  = (idx == lpt_pkg::IDX_IRQ_ENABLE);
  wire       hit_any  = aligned && in_range
                        && (hit_mode || hit_pwr || hit_hs || hit_vlo || hit_vhi
                        || hit_ls || hit_hb || hit_fs || hit_vb || hit_ist
                        || hit_icl || hit_ien);

  // Read mux; narrow registers sit in the low byte
  wire [7:0] rd_mode = {cfg.tft, 7'h00};
  wire [7:0] rd_pwr  = {6'h00, cfg.sleep ? lpt_pkg::PS_SLEEP : lpt_pkg::PS_NORMAL};
  wire [7:0] rd_vb   = {sync.vblank, 1'b0, cfg.vblank};
  wire [7:0] rd_ist  = 8'(irq_status);
  wire [7:0] rd_ien  = 8'(irq_enable);

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = !hit_any;
    if (hit_any && !pwrite_i)
    begin
      case (1'b1)
        hit_mode: next_rdata = {24'h00_0000, rd_mode};
        hit_pwr:  next_rdata = {24'h00_0000, rd_pwr};
        hit_hs:   next_rdata = {25'h000_0000, cfg.hsize};
        hit_vlo:  next_rdata = {24'h00_0000, cfg.vsize[7:0]};
        hit_vhi:  next_rdata = {30'h0000_0000, cfg.vsize[9:8]};
        hit_ls:   next_rdata = {27'h000_0000, cfg.lsync_pos};
        hit_hb:   next_rdata = {27'h000_0000, cfg.hblank};
        hit_fs:   next_rdata = {26'h000_0000, cfg.fsync_pos};
        hit_vb:   next_rdata = {24'h00_0000, rd_vb};
        hit_ist:  next_rdata = {24'h00_0000, rd_ist};
        hit_ien:  next_rdata = {24'h00_0000, rd_ien};
        default:  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // One wait-free answer: data is latched in setup, pready rises for access
  always_comb
  begin
    next_state = state;
    case (state)
      lpt_pkg::LPT_APB_IDLE: next_state = setup ? lpt_pkg::LPT_APB_DONE : lpt_pkg::LPT_APB_IDLE;
      lpt_pkg::LPT_APB_DONE: next_state = commit ? lpt_pkg::LPT_APB_IDLE : lpt_pkg::LPT_APB_DONE;
      default:               next_state = lpt_pkg::LPT_APB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state     <= lpt_pkg::LPT_APB_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      state    <= next_state;
      pready_o <= (next_state == lpt_pkg::LPT_APB_DONE);
      if (setup)
      begin
        prdata_o  <= next_rdata;
        pslverr_o <= next_err;
      end
      else if (commit)
      begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // Geometry and mode registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg <= '{tft: 1'b0, sleep: 1'b1, default: '0};
    end
    else if (wr)
    begin
      if (hit_mode)
        cfg.tft <= wd[lpt_pkg::TFT_BIT];
      if (hit_pwr && (wd[1:0] == lpt_pkg::PS_SLEEP))
        cfg.sleep <= 1'b1;
      if (hit_pwr && (wd[1:0] == lpt_pkg::PS_NORMAL))
        cfg.sleep <= 1'b0;
      if (hit_hs)
        cfg.hsize <= wd[6:0];
      if (hit_vlo)
        cfg.vsize[7:0] <= wd;
      if (hit_vhi)
        cfg.vsize[9:8] <= wd[1:0];
      if (hit_ls)
        cfg.lsync_pos <= wd[4:0];
      if (hit_hb)
        cfg.hblank <= wd[4:0];
      if (hit_fs)
        cfg.fsync_pos <= wd[5:0];
      // vertical blank; status bit ignores writes
      if (hit_vb)
        cfg.vblank <= wd[5:0];
    end
  end

  lpt_timing_gen #(
    .LSYNC_PIX (LSYNC_PIX)
  ) u_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cfg_i   (cfg),
    .sync_o  (sync),
    .evt_o   (evt)
  );

  // Sticky events; a new event beats a clear in the same cycle
  wire [lpt_pkg::IRQ_W-1:0] evt_bits = {evt.vb_end, evt.vb_start};
  wire [lpt_pkg::IRQ_W-1:0] clr_bits = (wr && hit_icl) ? wd[lpt_pkg::IRQ_W-1:0] : '0;

  assign next_status = (irq_status & ~clr_bits) | evt_bits;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      if (wr && hit_ien)
        irq_enable <= wd[lpt_pkg::IRQ_W-1:0];
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // Panel pins come straight from the generator flops
  assign line_sync_o         = sync.line_sync;
  assign frame_sync_o        = sync.frame_sync;
  assign panel_data_enable_o = sync.display_active;

endmodule : lpt_panel_timing

`default_nettype wire

// ---- rtl/lpt_pkg.sv ----
package lpt_pkg;

  // Register indices; byte address is the index shifted left by two
  localparam logic [7:0] IDX_PANEL_MODE = 8'h01;
  localparam logic [7:0] IDX_POWER_MODE = 8'h03;
  localparam logic [7:0] IDX_HSIZE      = 8'h04;
  localparam logic [7:0] IDX_VSIZE_LO   = 8'h05;
  localparam logic [7:0] IDX_VSIZE_HI   = 8'h06;
  localparam logic [7:0] IDX_LSYNC_POS  = 8'h07;
  localparam logic [7:0] IDX_HBLANK     = 8'h08;
  localparam logic [7:0] IDX_FSYNC_POS  = 8'h09;
  localparam logic [7:0] IDX_VBLANK     = 8'h0a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;
  localparam int         ADDR_W         = 12;
  localparam int         IDX_LSB        = 2;

  // Field positions
  localparam int TFT_BIT     = 7;
  localparam int VB_STAT_BIT = 7;

  // Power save codes
  localparam logic [1:0] PS_SLEEP  = 2'h0;
  localparam logic [1:0] PS_NORMAL = 2'h3;

  // Timing arithmetic
  localparam int GROUP_PIX   = 8;
  localparam int LSYNC_BIAS  = 2;
  localparam int HBLANK_BIAS = 4;
  localparam int CNT_W       = 11;

  // Interrupt bits
  localparam int IRQ_W        = 2;
  localparam int IRQ_VB_START = 0;
  localparam int IRQ_VB_END   = 1;

  typedef struct packed {
    logic       tft;
    logic       sleep;
    logic [6:0] hsize;
    logic [9:0] vsize;
    logic [4:0] lsync_pos;
    logic [4:0] hblank;
    logic [5:0] fsync_pos;
    logic [5:0] vblank;
  } lpt_cfg_t;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic display_active;
    logic vblank;
  } lpt_sync_t;

  typedef struct packed {
    logic vb_end;
    logic vb_start;
  } lpt_evt_t;

  typedef enum logic [1:0] {
    LPT_APB_IDLE = 2'h1,
    LPT_APB_DONE = 2'h2
  } lpt_apb_state_t;

endpackage : lpt_pkg

// ---- rtl/lpt_timing_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpt_timing_gen #(
  parameter int LSYNC_PIX = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire lpt_pkg::lpt_cfg_t cfg_i,
  output lpt_pkg::lpt_sync_t     sync_o,
  output lpt_pkg::lpt_evt_t      evt_o
);

  localparam int W = lpt_pkg::CNT_W;

  logic [W-1:0]       h_cnt;
  logic [W-1:0]       v_cnt;
  logic [W-1:0]       next_h;
  logic [W-1:0]       next_v;
  lpt_pkg::lpt_sync_t next_sync;

  wire [W-1:0] h_disp = W'((32'(cfg_i.hsize) + 1) * lpt_pkg::GROUP_PIX);
  wire [W-1:0] h_blank = W'((32'(cfg_i.hblank) + lpt_pkg::HBLANK_BIAS) * lpt_pkg::GROUP_PIX);
  wire [W-1:0] h_total = W'(h_disp + h_blank);
  wire [W-1:0] ls_tft = W'((32'(cfg_i.lsync_pos) + lpt_pkg::LSYNC_BIAS) * lpt_pkg::GROUP_PIX);
  wire [W-1:0] ls_start = cfg_i.tft ? W'(h_disp + ls_tft) : h_disp;
  wire [W-1:0] ls_end   = W'(ls_start + W'(LSYNC_PIX));
  wire [W-1:0] v_last = W'(cfg_i.vsize);
  wire [W-1:0] v_total = W'(32'(cfg_i.vsize) + 1 + 32'(cfg_i.vblank));
  wire [W-1:0] fs_line = cfg_i.tft ? W'(v_last + W'(cfg_i.fsync_pos)) : W'(v_last + 1);
  wire         h_wrap  = (h_cnt == W'(h_total - 1));
  wire         v_wrap  = (v_cnt == W'(v_total - 1));
  wire         in_vb   = (v_cnt > v_last);

  assign next_h = h_wrap ? '0 : W'(h_cnt + 1);
  assign next_v = !h_wrap ? v_cnt : (v_wrap ? '0 : W'(v_cnt + 1));

  assign next_sync.line_sync      = (h_cnt >= ls_start) && (h_cnt < ls_end);
  assign next_sync.frame_sync     = (v_cnt == fs_line) && in_vb;
  assign next_sync.display_active = (h_cnt < h_disp) && !in_vb;
  assign next_sync.vblank         = in_vb;

  // Power save parks counters so the panel sees a quiet bus
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_i.sleep)
    begin
      h_cnt  <= '0;
      v_cnt  <= '0;
      sync_o <= '0;
      evt_o  <= '0;
    end
    else
    begin
      h_cnt           <= next_h;
      v_cnt           <= next_v;
      sync_o          <= next_sync;
      evt_o.vb_start  <= next_sync.vblank && !sync_o.vblank;
      evt_o.vb_end    <= !next_sync.vblank && sync_o.vblank;
    end
  end

endmodule : lpt_timing_gen

`default_nettype wire

// ---- verification/lpt_panel_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpt_panel_model (
  input  wire logic        clk_i,
  input  wire logic        line_sync_i,
  input  wire logic        frame_sync_i,
  input  wire logic        data_enable_i,
  output logic      [15:0] line_len_o,
  output logic      [15:0] sync_lead_o,
  output logic      [15:0] de_len_o,
  output logic      [15:0] frame_len_o,
  output logic      [15:0] fs_lead_o,
  output logic      [15:0] de_lines_o
);
  logic        ls_q, fs_q, de_q, de_seen;
  logic [15:0] c_ls, c_de, c_on, c_fs, n_de;
  wire         ls_up = line_sync_i && !ls_q;
  wire         fs_up = frame_sync_i && !fs_q;
  wire         de_up = data_enable_i && !de_q;
  wire         de_dn = !data_enable_i && de_q;

  // Panel only measures; first figures after start are not meaningful
  always_ff @(posedge clk_i)
  begin
    ls_q <= line_sync_i;
    fs_q <= frame_sync_i;
    de_q <= data_enable_i;
    c_ls <= ls_up ? 16'h0 : c_ls + 16'h1;
    if (ls_up) line_len_o <= c_ls + 16'h1;
    // sync after data
    // Blank lines carry no data, so only a line with data yields a lead
    c_de <= de_dn ? 16'h0 : c_de + 16'h1;
    if (ls_up && (de_dn || de_seen)) sync_lead_o <= de_dn ? 16'h0 : c_de + 16'h1;
    if (ls_up) de_seen <= 1'b0;
    else if (de_dn) de_seen <= 1'b1;
    c_on <= de_up ? 16'h0 : c_on + 16'h1;
    if (de_dn) de_len_o <= c_on + 16'h1;
    c_fs <= fs_up ? 16'h0 : c_fs + 16'h1;
    if (fs_up) frame_len_o <= c_fs + 16'h1;
    if (fs_up) fs_lead_o <= c_de + 16'h1;
    n_de <= fs_up ? 16'h0 : n_de + {15'h0, de_up};
    if (fs_up) de_lines_o <= n_de;
  end
endmodule : lpt_panel_model

`default_nettype wire

// ---- verification/lpt_panel_timing_chk.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpt_panel_timing_chk #(
  parameter int LSYNC_PIX = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        line_sync_o,
  input wire logic        frame_sync_o,
  input wire logic        panel_data_enable_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_rdy_one;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("no ready after setup");
  property p_rdy_drop;
    psel_i && penable_i && pready_o |=> !pready_o;
  endproperty
  a_rdy_drop: assert property (p_rdy_drop) else $error("ready held too long");
  property p_err_data;
    pslverr_o |-> pready_o && prdata_o == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error without ready or zero data");
  // Width is fixed at the default of eight pixels
  property p_ls_width;
    $rose(line_sync_o) |-> line_sync_o [*8] ##1 !line_sync_o;
  endproperty
  a_ls_width: assert property (p_ls_width) else $error("line sync width");
  property p_ls_blank;
    line_sync_o |-> !panel_data_enable_o;
  endproperty
  a_ls_blank: assert property (p_ls_blank) else $error("line sync in display");
  // One group at least makes 8 pixels, all 8 are checked here
  property p_de_min;
    $rose(panel_data_enable_o) |-> panel_data_enable_o [*8];
  endproperty
  a_de_min: assert property (p_de_min) else $error("display run too short");
  property p_fs_blank;
    $rose(frame_sync_o) |-> !line_sync_o && !panel_data_enable_o;
  endproperty
  a_fs_blank: assert property (p_fs_blank) else $error("frame sync misplaced");
  property p_fs_de;
    frame_sync_o |-> !panel_data_enable_o;
  endproperty
  a_fs_de: assert property (p_fs_de) else $error("frame sync in display");
  // Reset itself is the cause here, so it cannot be the disable
  property p_rst;
    disable iff (1'b0)
    !rst_n_i |=> !line_sync_o && !frame_sync_o && !panel_data_enable_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : lpt_panel_timing_chk

bind lpt_panel_timing lpt_panel_timing_chk #(.LSYNC_PIX(LSYNC_PIX)) i_lpt_panel_timing_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .line_sync_o(line_sync_o), .frame_sync_o(frame_sync_o),
  .panel_data_enable_o(panel_data_enable_o), .irq_o(irq_o)
);

`default_nettype wire

// ---- verification/lpt_panel_timing_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpt_panel_timing_test;
  logic                       clk_i;
  logic                       rst_n_i = 1'b0;
  logic                       psel_i = 1'b0;
  logic                       penable_i = 1'b0;
  logic                       pwrite_i = 1'b0;
  logic [lpt_pkg::ADDR_W-1:0] paddr_i = '0;
  logic [31:0]                pwdata_i = '0;
  logic [31:0]                rd_s;
  logic                       er_s;
  wire logic [31:0]           prdata_o;
  wire logic                  pready_o, pslverr_o, line_sync_o, frame_sync_o;
  wire logic                  panel_data_enable_o, irq_o;
  wire logic [15:0]           line_len, sync_lead, de_len, frame_len, fs_lead, de_lines;
  int                         err_total = 0;
  int                         n_compared = 0;
  int                         k;

  lpt_panel_timing i_lpt_panel_timing (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .line_sync_o(line_sync_o),
    .frame_sync_o(frame_sync_o), .panel_data_enable_o(panel_data_enable_o), .irq_o(irq_o));
  lpt_panel_model i_lpt_panel_model (
    .clk_i(clk_i), .line_sync_i(line_sync_o), .frame_sync_i(frame_sync_o),
    .data_enable_i(panel_data_enable_o), .line_len_o(line_len), .sync_lead_o(sync_lead),
    .de_len_o(de_len), .frame_len_o(frame_len), .fs_lead_o(fs_lead), .de_lines_o(de_lines));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until ready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // Only the watchdog ends a wait for ready
    while (pready_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd_s = prdata_o;
    er_s = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic err);
    apb(1'b0, idx, 32'h0);
    check(rd_s, exp);
    check({31'h0, er_s}, {31'h0, err});
  endtask : rd

  function automatic logic sig(input int w);
    return w == 0 ? frame_sync_o : (w == 1 ? panel_data_enable_o : irq_o);
  endfunction : sig

  task automatic wait_lvl(input int w, input logic lvl);
    int n;
    n = 0;
    while (sig(w) !== lvl && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, sig(w)}, {31'h0, lvl});
  endtask : wait_lvl

  task automatic wait_fs(input int cnt);
    repeat (cnt)
    begin
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
    end
  endtask : wait_fs

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 3; i <= 10; i++)
      rd(i[7:0], 32'h0, 1'b0);
    rd(8'h3f, 32'h0, 1'b1);
    $display("Test reset values done");
    wr(lpt_pkg::IDX_HSIZE, 32'h3);
    wr(lpt_pkg::IDX_VSIZE_LO, 32'h3);
    wr(lpt_pkg::IDX_VSIZE_HI, 32'h0);
    wr(lpt_pkg::IDX_LSYNC_POS, 32'h1);
    wr(lpt_pkg::IDX_HBLANK, 32'h1);
    wr(lpt_pkg::IDX_FSYNC_POS, 32'h2);
    wr(lpt_pkg::IDX_VBLANK, 32'h2);
    wr(lpt_pkg::IDX_PANEL_MODE, 32'h80);
    wr(lpt_pkg::IDX_POWER_MODE, 32'h3);
    wait_fs(2);
    check({16'h0, line_len}, 32'd72);
    check({16'h0, de_len}, 32'd32);
    check({16'h0, sync_lead}, 32'd24);
    check({16'h0, frame_len}, 32'd432);
    check({16'h0, de_lines}, 32'd4);
    check({16'h0, fs_lead}, 32'd112);
    wait_lvl(0, 1'b1);
    rd(lpt_pkg::IDX_VBLANK, 32'h82, 1'b0);
    wait_lvl(1, 1'b1);
    rd(lpt_pkg::IDX_VBLANK, 32'h02, 1'b0);
    $display("Test tft timing done");
    wr(lpt_pkg::IDX_PANEL_MODE, 32'h0);
    wait_fs(2);
    check({16'h0, sync_lead}, 32'd0);
    check({16'h0, fs_lead}, 32'd40);
    $display("Test passive timing done");
    // Stale events are cleared first so the level below comes from a fresh one
    wr(lpt_pkg::IDX_IRQ_CLEAR, 32'h3);
    wr(lpt_pkg::IDX_IRQ_ENABLE, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    wait_lvl(2, 1'b1);
    wr(lpt_pkg::IDX_IRQ_CLEAR, 32'h3);
    rd(lpt_pkg::IDX_IRQ_STATUS, 32'h0, 1'b0);
    check({31'h0, irq_o}, 32'h0);
    wr(lpt_pkg::IDX_IRQ_ENABLE, 32'h0);
    wait_fs(2);
    rd(lpt_pkg::IDX_IRQ_STATUS, 32'h3, 1'b0);
    check({31'h0, irq_o}, 32'h0);
    $display("Test interrupt done");
    // Reserved codes must leave the running mode alone
    wr(lpt_pkg::IDX_POWER_MODE, 32'h1);
    wait_fs(1);
    wr(lpt_pkg::IDX_POWER_MODE, 32'h0);
    wr(lpt_pkg::IDX_POWER_MODE, 32'h2);
    k = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      if ({line_sync_o, frame_sync_o, panel_data_enable_o} !== 3'h0) k++;
    end
    check(k, 32'h0);
    wr(lpt_pkg::IDX_VSIZE_LO, 32'hff);
    wr(lpt_pkg::IDX_VSIZE_HI, 32'hff);
    rd(lpt_pkg::IDX_VSIZE_LO, 32'hff, 1'b0);
    rd(lpt_pkg::IDX_VSIZE_HI, 32'h03, 1'b0);
    wr(lpt_pkg::IDX_HSIZE, 32'hff);
    rd(lpt_pkg::IDX_HSIZE, 32'h7f, 1'b0);
    wr(lpt_pkg::IDX_VBLANK, 32'hff);
    rd(lpt_pkg::IDX_VBLANK, 32'h3f, 1'b0);
    $display("Test power and fields done");
    give_verdict();
  end

  initial
  begin
    #200000;
    err_total++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : lpt_panel_timing_test

`default_nettype wire
